/* core/t16_cfg.svh */
// register offsets, field positions, codes and reset values for the 16-bit timer
// assumes the includer places the constants next to byte addresses on AHB-Lite
`ifndef T16_CFG_SVH
`define T16_CFG_SVH
// ==========================================
// register byte offsets
`define T16_ADDR_CTRL 8'h00
`define T16_ADDR_FORCE 8'h04
`define T16_ADDR_COUNT 8'h08
`define T16_ADDR_CMPA 8'h0c
`define T16_ADDR_CMPB 8'h10
`define T16_ADDR_CAPT 8'h14
`define T16_ADDR_FLAGS 8'h18
`define T16_ADDR_PINS 8'h1c
`define T16_ADDR_STEP 8'h04
// ==========================================
// control fields
`define T16_F_WGM 3:0
`define T16_F_COM_LO 4
`define T16_F_CS 10:8
`define T16_CTRL_W 11
`define T16_CTRL_RST 11'h000
// ==========================================
// waveform mode codes
`define T16_WGM_NORMAL 4'h0
`define T16_WGM_CTC_A 4'h4
`define T16_WGM_CTC_C 4'hc
`define T16_WGM_FP8 4'h5
`define T16_WGM_FP9 4'h6
`define T16_WGM_FP10 4'h7
`define T16_WGM_FP_C 4'he
`define T16_WGM_FP_A 4'hf
// ==========================================
// compare output mode codes
`define T16_COM_OFF 2'h0
`define T16_COM_TGL 2'h1
`define T16_COM_CLR 2'h2
`define T16_COM_SET 2'h3
// ==========================================
// counter values
`define T16_ZERO 16'h0000
`define T16_MAX 16'hffff
`define T16_TOP8 16'h00ff
`define T16_TOP9 16'h01ff
`define T16_TOP10 16'h03ff
// ==========================================
// prescaler select codes and divider masks
`define T16_CS_DIV1 3'h1
`define T16_CS_DIV8 3'h2
`define T16_CS_DIV64 3'h3
`define T16_CS_DIV256 3'h4
`define T16_CS_DIV1024 3'h5
`define T16_PRE_M8 10'h007
`define T16_PRE_M64 10'h03f
`define T16_PRE_M256 10'h0ff
`define T16_PRE_M1024 10'h3ff
// ==========================================
// flag bits
`define T16_FLAG_OVF 0
`define T16_FLAG_CMPA 1
`define T16_FLAG_CAPT 3
// ==========================================
// register reset values
`define T16_PAIR_RST 2'h0
`define T16_FLAGS_RST 4'h0
`define T16_PINS_RST 4'h0
`define T16_PRE_RST 10'h000
`define T16_ADR_RST 8'h00
`define T16_WORD_RST 32'h00000000
`endif

/* core/t16_pkg.sv */
// types shared by the 16-bit timer design and its bench
// assumes t16_cfg.svh holds every number except the one-hot class codes set here
package t16_pkg;
  // ==========================================
  // counting class, one-hot
  typedef enum logic [3:0] {
    T16_CLS_NORMAL = 4'h1,
    T16_CLS_CTC = 4'h2,
    T16_CLS_FAST = 4'h4,
    T16_CLS_OTHER = 4'h8
  } t16_cls_t;
  // ==========================================
  // compare pins, index 0 is channel a
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } t16_pin_t;
  // ==========================================
  // status flags
  typedef struct packed {
    logic capt;
    logic cmpb;
    logic cmpa;
    logic ovf;
  } t16_flags_t;
endpackage : t16_pkg

/* core/t16_timer.sv */
// 16-bit timer: normal, clear-on-match and fast pwm counting, two compare channels
// assumes one clock, an AHB-Lite master with single word transfers, pins resolved outside
`timescale 1ns/100ps
`include "t16_cfg.svh"
module t16_timer (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [3:0] flag_service_ack,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output t16_pkg::t16_pin_t pins_o
);
  // ==========================================
  // state
  logic [`T16_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] capt_ff, nxt_capt;
  t16_pkg::t16_flags_t flags_ff, nxt_flags;
  logic [1:0] dir_ff, nxt_dir;
  logic [1:0] port_ff, nxt_port;
  logic [9:0] pre_ff, nxt_pre;
  logic blk_ff, nxt_blk;
  logic [7:0] adr_ff, nxt_adr;
  logic wph_ff, nxt_wph;
  logic [31:0] hrdata_ff, nxt_hrdata;
  t16_pkg::t16_pin_t pins_ff, nxt_pins;
  logic hready_ff, nxt_hready;
  logic hresp_ff, nxt_hresp;
  // ==========================================
  // decoded signals
  t16_pkg::t16_cls_t cls;
  logic [3:0] wgm;
  logic [15:0] top, wmask;
  logic regtop, top_capt, tick, at_top, acc;
  logic wr_ctrl, wr_force, wr_cnt, wr_capt, wr_flags, wr_pins;
  logic [1:0][15:0] buf_v, act_v;
  logic [1:0] latch_v, match_v, pin_out_v;
  logic [31:0] rd_mux;

  assign wgm = ctrl_ff[`T16_F_WGM];
  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;
  assign pins_o = pins_ff;

  // ==========================================
  // mode decode
  // mode field alone picks top
  always_comb begin
    cls = t16_pkg::T16_CLS_OTHER;
    top = `T16_MAX;
    regtop = 1'b0;
    top_capt = 1'b0;
    wmask = `T16_MAX;
    case (wgm)
      `T16_WGM_NORMAL: begin
        cls = t16_pkg::T16_CLS_NORMAL;
      end
      `T16_WGM_CTC_A: begin
        cls = t16_pkg::T16_CLS_CTC;
        top = act_v[0];
        regtop = 1'b1;
      end
      `T16_WGM_CTC_C: begin
        cls = t16_pkg::T16_CLS_CTC;
        top = capt_ff;
        regtop = 1'b1;
        top_capt = 1'b1;
      end
      `T16_WGM_FP8: begin
        cls = t16_pkg::T16_CLS_FAST;
        top = `T16_TOP8;
        wmask = `T16_TOP8;
      end
      `T16_WGM_FP9: begin
        cls = t16_pkg::T16_CLS_FAST;
        top = `T16_TOP9;
        wmask = `T16_TOP9;
      end
      `T16_WGM_FP10: begin
        cls = t16_pkg::T16_CLS_FAST;
        top = `T16_TOP10;
        wmask = `T16_TOP10;
      end
      `T16_WGM_FP_C: begin
        cls = t16_pkg::T16_CLS_FAST;
        top = capt_ff;
        regtop = 1'b1;
        top_capt = 1'b1;
      end
      `T16_WGM_FP_A: begin
        cls = t16_pkg::T16_CLS_FAST;
        top = act_v[0];
        regtop = 1'b1;
      end
      default: begin
        cls = t16_pkg::T16_CLS_OTHER;
      end
    endcase
  end

  // ==========================================
  // prescaler
  // timer tick from divided clock
  always_comb begin
    nxt_pre = pre_ff + 10'h001;
    case (ctrl_ff[`T16_F_CS])
      `T16_CS_DIV1: tick = 1'b1;
      `T16_CS_DIV8: tick = (pre_ff & `T16_PRE_M8) == `T16_PRE_M8;
      `T16_CS_DIV64: tick = (pre_ff & `T16_PRE_M64) == `T16_PRE_M64;
      `T16_CS_DIV256: tick = (pre_ff & `T16_PRE_M256) == `T16_PRE_M256;
      `T16_CS_DIV1024: tick = pre_ff == `T16_PRE_M1024;
      default: tick = 1'b0;
    endcase
  end

  // ==========================================
  // bus slave
  // zero wait states, so read data is fetched at the address phase
  assign acc = hsel & htrans[1] & hready;
  assign wr_ctrl = wph_ff & (adr_ff == `T16_ADDR_CTRL);
  assign wr_force = wph_ff & (adr_ff == `T16_ADDR_FORCE);
  assign wr_cnt = wph_ff & (adr_ff == `T16_ADDR_COUNT);
  assign wr_capt = wph_ff & (adr_ff == `T16_ADDR_CAPT);
  assign wr_flags = wph_ff & (adr_ff == `T16_ADDR_FLAGS);
  assign wr_pins = wph_ff & (adr_ff == `T16_ADDR_PINS);

  always_comb begin
    case (haddr[7:0])
      `T16_ADDR_CTRL: rd_mux = {21'h000000, ctrl_ff};
      `T16_ADDR_COUNT: rd_mux = {16'h0000, cnt_ff};
      `T16_ADDR_CMPA: rd_mux = {16'h0000, buf_v[0]};
      `T16_ADDR_CMPB: rd_mux = {16'h0000, buf_v[1]};
      `T16_ADDR_CAPT: rd_mux = {16'h0000, capt_ff};
      `T16_ADDR_FLAGS: rd_mux = {28'h0000000, flags_ff};
      `T16_ADDR_PINS: rd_mux = {26'h0000000, latch_v, port_ff, dir_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    nxt_wph = acc & hwrite;
    nxt_adr = acc ? haddr[7:0] : adr_ff;
    nxt_hrdata = (acc & ~hwrite) ? rd_mux : 32'h00000000;
    nxt_ctrl = wr_ctrl ? hwdata[`T16_CTRL_W-1:0] : ctrl_ff;
    nxt_capt = wr_capt ? hwdata[15:0] : capt_ff;
    nxt_dir = wr_pins ? hwdata[1:0] : dir_ff;
    nxt_port = wr_pins ? hwdata[3:2] : port_ff;
    // every access answers in one cycle, always okay
    nxt_hready = 1'b1;
    nxt_hresp = 1'b0;
  end

  // ==========================================
  // counter
  // blocked top match lets counter run on
  assign at_top = (cls == t16_pkg::T16_CLS_CTC || cls == t16_pkg::T16_CLS_FAST)
                  && cnt_ff == top && !(blk_ff && regtop);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (tick) begin
      nxt_cnt = at_top ? `T16_ZERO : cnt_ff + 16'h0001;
    end
    if (wr_cnt) begin
      nxt_cnt = hwdata[15:0];
    end
    // block holds until the next tick
    nxt_blk = wr_cnt ? 1'b1 : (tick ? 1'b0 : blk_ff);
  end

  // ==========================================
  // flags
  // set wins over both kinds of clear
  always_comb begin
    nxt_flags = flags_ff & ~flag_service_ack;
    if (wr_flags) begin
      nxt_flags = nxt_flags & ~hwdata[3:0];
    end
    if (tick) begin
      if (cls != t16_pkg::T16_CLS_FAST && cnt_ff == `T16_MAX) begin
        nxt_flags[`T16_FLAG_OVF] = 1'b1;
      end
      if (cls == t16_pkg::T16_CLS_FAST && at_top) begin
        nxt_flags[`T16_FLAG_OVF] = 1'b1;
      end
      if (at_top && regtop) begin
        nxt_flags[top_capt ? `T16_FLAG_CAPT : `T16_FLAG_CMPA] = 1'b1;
      end
      nxt_flags[2:1] = nxt_flags[2:1] | match_v;
    end
  end

  // ==========================================
  // compare channels
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic [15:0] buf_ff, nxt_buf, act_ff, nxt_act;
      logic latch_ff, nxt_latch;
      logic [1:0] com;
      logic wr_cmp, force_c, act_now;
      logic pin_c;

      assign com = ctrl_ff[`T16_F_COM_LO + 2 * c +: 2];
      assign wr_cmp = wph_ff && adr_ff == 8'(`T16_ADDR_CMPA + `T16_ADDR_STEP * c);
      assign force_c = wr_force && hwdata[c] && cls != t16_pkg::T16_CLS_FAST;
      assign match_v[c] = tick && !blk_ff && cnt_ff == act_ff;
      assign act_now = match_v[c] || force_c;
      assign buf_v[c] = buf_ff;
      assign act_v[c] = act_ff;
      assign latch_v[c] = latch_ff;
      assign pin_out_v[c] = pin_c;

      always_comb begin
        nxt_buf = wr_cmp ? (hwdata[15:0] & wmask) : buf_ff;
        // active copy loads at top in fast pwm
        if (cls == t16_pkg::T16_CLS_FAST) begin
          nxt_act = (tick && at_top) ? buf_ff : act_ff;
        end else begin
          nxt_act = nxt_buf;
        end
        nxt_latch = latch_ff;
        // field read only at the action itself
        if (cls == t16_pkg::T16_CLS_FAST) begin
          if (tick) begin
            // top first, match wins a tie
            if (com == `T16_COM_CLR) begin
              nxt_latch = match_v[c] ? 1'b1 : (at_top ? 1'b0 : latch_ff);
            end else if (com == `T16_COM_SET) begin
              nxt_latch = match_v[c] ? 1'b0 : (at_top ? 1'b1 : latch_ff);
            end else if (com == `T16_COM_TGL && c == 0 && wgm == `T16_WGM_FP_A && match_v[c]) begin
              nxt_latch = ~latch_ff;
            end
          end
        end else if (cls != t16_pkg::T16_CLS_OTHER && act_now) begin
          // off keeps, toggle, force acts alike
          case (com)
            `T16_COM_TGL: nxt_latch = ~latch_ff;
            `T16_COM_CLR: nxt_latch = 1'b0;
            `T16_COM_SET: nxt_latch = 1'b1;
            default: nxt_latch = latch_ff;
          endcase
        end
        // latch overrides port data when enabled
        pin_c = (com != `T16_COM_OFF) ? nxt_latch : nxt_port[c];
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          buf_ff <= `T16_ZERO;
          act_ff <= `T16_ZERO;
          latch_ff <= 1'b0;
        end else begin
          buf_ff <= nxt_buf;
          act_ff <= nxt_act;
          latch_ff <= nxt_latch;
        end
      end
    end
  endgenerate

  // ==========================================
  // pins
  // drive only when direction is output
  always_comb begin
    nxt_pins.out = pin_out_v;
    nxt_pins.oe = nxt_dir;
  end

  // ==========================================
  // bus registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= `T16_CTRL_RST;
      capt_ff <= `T16_ZERO;
      dir_ff <= `T16_PAIR_RST;
      port_ff <= `T16_PAIR_RST;
      adr_ff <= `T16_ADR_RST;
      wph_ff <= 1'b0;
      hrdata_ff <= `T16_WORD_RST;
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      capt_ff <= nxt_capt;
      dir_ff <= nxt_dir;
      port_ff <= nxt_port;
      adr_ff <= nxt_adr;
      wph_ff <= nxt_wph;
      hrdata_ff <= nxt_hrdata;
      hready_ff <= nxt_hready;
      hresp_ff <= nxt_hresp;
    end
  end

  // ==========================================
  // counter registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= `T16_ZERO;
      pre_ff <= `T16_PRE_RST;
      blk_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      pre_ff <= nxt_pre;
      blk_ff <= nxt_blk;
    end
  end

  // ==========================================
  // flag registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flags_ff <= `T16_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ==========================================
  // pin registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pins_ff <= `T16_PINS_RST;
    end else begin
      pins_ff <= nxt_pins;
    end
  end
endmodule : t16_timer

/* dv/t16_timer_monitor.sv */
// checker for the 16-bit timer, watching its ports only
// assumes an AHB-Lite slave that never inserts wait states
`timescale 1ns/100ps
`include "t16_cfg.svh"
module t16_timer_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire t16_pkg::t16_pin_t pins_o
);
  // ==========================================
  // data phase tracking
  logic rd_ff;
  logic wr_ff;
  logic [7:0] adr_ff;
  logic nxt_rd;
  logic nxt_wr;
  logic [7:0] nxt_adr;
  logic wr_pins;
  always_comb begin
    nxt_rd = hsel & htrans[1] & hready & !hwrite;
    nxt_wr = hsel & htrans[1] & hready & hwrite;
    nxt_adr = haddr[7:0];
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      adr_ff <= 8'h00;
    end else begin
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      adr_ff <= nxt_adr;
    end
  end
  assign wr_pins = wr_ff & (adr_ff == `T16_ADDR_PINS);
  // ==========================================
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_READY_HIGH: assert property (hreadyout == 1'b1) else $error("slave stretched a transfer");
  AST_RESP_OKAY: assert property (hresp == 1'b0) else $error("slave gave an error response");
  AST_RDATA_IDLE: assert property (!rd_ff |-> hrdata == 32'h0) else $error("read data outside a data phase");
  AST_FORCE_RD_ZERO: assert property (rd_ff && adr_ff == `T16_ADDR_FORCE |-> hrdata == 32'h0)
    else $error("force strobe reads back nonzero");
  AST_FLAGS_WIDTH: assert property (rd_ff && adr_ff == `T16_ADDR_FLAGS |-> hrdata[31:4] == 28'h0)
    else $error("flag word has upper bits set");
  AST_COUNT_WIDTH: assert property (rd_ff && adr_ff == `T16_ADDR_COUNT |-> hrdata[31:16] == 16'h0)
    else $error("counter wider than 16 bits");
  AST_CTRL_WIDTH: assert property (rd_ff && adr_ff == `T16_ADDR_CTRL |-> hrdata[31:11] == 21'h0)
    else $error("control word has upper bits set");
  AST_DIR_READBACK: assert property (rd_ff && adr_ff == `T16_ADDR_PINS |-> hrdata[1:0] == $past(pins_o.oe))
    else $error("direction readback differs from pin enable");
  AST_OE_ONLY_BY_WRITE: assert property ($changed(pins_o.oe) |-> $past(wr_pins))
    else $error("pin enable moved without a direction write");
  // ==========================================
  // scenario coverage
  COV_PINS_READ: cover property (rd_ff && adr_ff == `T16_ADDR_PINS);
  COV_OE_CHANGE: cover property ($changed(pins_o.oe));
  COV_OVF_SEEN: cover property (rd_ff && adr_ff == `T16_ADDR_FLAGS && hrdata[0]);
endmodule : t16_timer_monitor

bind t16_timer t16_timer_monitor u_mon (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .pins_o(pins_o));

/* dv/t16_load.sv */
// load on the compare pins: pull-down pads and a pulse meter on channel a
// assumes pins_o from the timer, one clock domain
`timescale 1ns/100ps
module t16_load (
  input wire logic clock,
  input wire logic rstn,
  input wire t16_pkg::t16_pin_t pins_o,
  output logic [1:0] pad,
  output logic [15:0] hi_len,
  output logic [15:0] period
);
  logic prev_ff;
  logic [15:0] run_ff;
  logic [15:0] age_ff;
  // ==========================================
  // pad follows the pin output (latch or port data) only when driven
  // an undriven pad falls to its pull-down, never the last value
  assign pad[0] = pins_o.oe[0] ? pins_o.out[0] : 1'b0;
  assign pad[1] = pins_o.oe[1] ? pins_o.out[1] : 1'b0;
  // ==========================================
  // high time and period of the last full pulse
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev_ff <= 1'b0;
      run_ff <= 16'h0000;
      age_ff <= 16'h0000;
      hi_len <= 16'h0000;
      period <= 16'h0000;
    end else begin
      prev_ff <= pad[0];
      run_ff <= (pad[0] != prev_ff) ? 16'h0001 : run_ff + 16'h0001;
      age_ff <= (pad[0] && !prev_ff) ? 16'h0001 : age_ff + 16'h0001;
      if (!pad[0] && prev_ff) hi_len <= run_ff;
      if (pad[0] && !prev_ff) period <= age_ff;
    end
  end
endmodule : t16_load

/* dv/t16_timer_tb.sv */
// self-checking bench for the 16-bit timer over AHB-Lite
// assumes a zero-wait slave; the load model measures channel a
`timescale 1ns/100ps
`include "t16_cfg.svh"
module t16_timer_tb;
  logic clock;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic [3:0] ack;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  t16_pkg::t16_pin_t pins_o;
  logic [1:0] pad;
  logic [15:0] hi_len;
  logic [15:0] period;
  logic [31:0] rd;
  int errors;
  int samples_checked;
  assign hready = hreadyout;
  t16_timer DUT (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .flag_service_ack(ack), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pins_o(pins_o));
  t16_load u_load (.clock(clock), .rstn(rstn), .pins_o(pins_o), .pad(pad), .hi_len(hi_len), .period(period));
  // ==========================================
  // reporting and bus access
  task automatic finish_test;
    $display("errors=%0d checks=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clock);
    while (hready !== 1'b1) begin
      n++;
      if (n > 100) begin
        errors++;
        finish_test();
      end
      @(posedge clock);
    end
  endtask : wait_rdy
  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(exp, rd);
  endtask : rdc
  // ==========================================
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 9; i++) begin
      rdc(8'(i * 4), 32'h0);
    end
  endtask : t_reset
  task automatic t_normal;
    wr(`T16_ADDR_COUNT, 32'hfff0);
    wr(`T16_ADDR_CTRL, 32'h100);
    repeat (40) @(posedge clock);
    wr(`T16_ADDR_CTRL, 32'h0);
    bus(1'b0, `T16_ADDR_COUNT, 32'h0);
    chk(32'h1, {31'h0, rd < 32'h40});
    rdc(`T16_ADDR_FLAGS, 32'h7);
    wr(`T16_ADDR_FLAGS, 32'h1);
    rdc(`T16_ADDR_FLAGS, 32'h6);
    ack <= 4'h6;
    @(posedge clock);
    ack <= 4'h0;
    rdc(`T16_ADDR_FLAGS, 32'h0);
  endtask : t_normal
  // one waveform setup, then pulse shape and flags
  task automatic t_run(input logic [31:0] ctrl, cmpa, capt, hi, per, flg, input int n);
    wr(`T16_ADDR_CTRL, 32'h0);
    wr(`T16_ADDR_COUNT, 32'h0);
    wr(`T16_ADDR_CMPA, cmpa);
    wr(`T16_ADDR_CAPT, capt);
    wr(`T16_ADDR_PINS, 32'h1);
    wr(`T16_ADDR_FLAGS, 32'hf);
    wr(`T16_ADDR_CTRL, ctrl);
    repeat (n) @(posedge clock);
    rdc(`T16_ADDR_FLAGS, flg);
    chk(hi, {16'h0, hi_len});
    chk(per, {16'h0, period});
  endtask : t_run
  task automatic t_wave;
    t_run(32'h114, 32'h3, 32'h0, 32'h4, 32'h8, 32'h6, 60);
    t_run(32'h11c, 32'h3, 32'h7, 32'h8, 32'h10, 32'he, 80);
    t_run(32'h12e, 32'h3, 32'h9, 32'h6, 32'ha, 32'hf, 60);
    t_run(32'h13e, 32'h3, 32'h9, 32'h4, 32'ha, 32'hf, 60);
    t_run(32'h11f, 32'h3, 32'h0, 32'h4, 32'h8, 32'h7, 60);
    t_run(32'h125, 32'h80, 32'h0, 32'h7f, 32'h100, 32'h7, 700);
    t_run(32'h214, 32'h3, 32'h0, 32'h20, 32'h40, 32'h6, 200);
    t_run(32'h314, 32'h3, 32'h0, 32'h100, 32'h200, 32'h6, 1200);
    t_run(32'h414, 32'h3, 32'h0, 32'h400, 32'h800, 32'h6, 4500);
    t_run(32'h514, 32'h3, 32'h0, 32'h1000, 32'h2000, 32'h6, 18000);
  endtask : t_wave
  task automatic t_force;
    wr(`T16_ADDR_CTRL, 32'h10);
    wr(`T16_ADDR_PINS, 32'h0);
    bus(1'b0, `T16_ADDR_PINS, 32'h0);
    if (rd[4] !== 1'b1) wr(`T16_ADDR_FORCE, 32'h1);
    wr(`T16_ADDR_FLAGS, 32'hf);
    @(posedge clock);
    chk(32'h0, {31'h0, pad[0]});
    wr(`T16_ADDR_PINS, 32'h1);
    @(posedge clock);
    chk(32'h1, {31'h0, pad[0]});
    wr(`T16_ADDR_PINS, 32'hb);
    @(posedge clock);
    chk(32'h1, {31'h0, pad[1]});
    wr(`T16_ADDR_PINS, 32'h1);
    wr(`T16_ADDR_FORCE, 32'h1);
    rdc(`T16_ADDR_PINS, 32'h1);
    rdc(`T16_ADDR_FLAGS, 32'h0);
    wr(`T16_ADDR_CTRL, 32'h15);
    wr(`T16_ADDR_FORCE, 32'h1);
    rdc(`T16_ADDR_PINS, 32'h1);
    wr(`T16_ADDR_CTRL, 32'h0);
    wr(`T16_ADDR_FORCE, 32'h1);
    rdc(`T16_ADDR_PINS, 32'h1);
  endtask : t_force
  task automatic t_block;
    wr(`T16_ADDR_CTRL, 32'h5);
    wr(`T16_ADDR_CMPA, 32'hff80);
    rdc(`T16_ADDR_CMPA, 32'h80);
    wr(`T16_ADDR_CTRL, 32'h6);
    wr(`T16_ADDR_CMPA, 32'hffff);
    rdc(`T16_ADDR_CMPA, 32'h1ff);
    wr(`T16_ADDR_CTRL, 32'h7);
    wr(`T16_ADDR_CMPA, 32'hffff);
    rdc(`T16_ADDR_CMPA, 32'h3ff);
    wr(`T16_ADDR_CTRL, 32'h4);
    wr(`T16_ADDR_CMPA, 32'h5);
    wr(`T16_ADDR_COUNT, 32'h5);
    wr(`T16_ADDR_FLAGS, 32'hf);
    wr(`T16_ADDR_CTRL, 32'h104);
    repeat (20) @(posedge clock);
    wr(`T16_ADDR_CTRL, 32'h4);
    rdc(`T16_ADDR_FLAGS, 32'h0);
    bus(1'b0, `T16_ADDR_COUNT, 32'h0);
    chk(32'h1, {31'h0, rd > 32'h6});
    wr(`T16_ADDR_COUNT, 32'hfff0);
    wr(`T16_ADDR_FLAGS, 32'hf);
    wr(`T16_ADDR_CTRL, 32'h104);
    repeat (30) @(posedge clock);
    wr(`T16_ADDR_CTRL, 32'h4);
    rdc(`T16_ADDR_FLAGS, 32'h7);
  endtask : t_block
  // ==========================================
  // clock, reset, sequence and hang guard
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ack = 4'h0;
    errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_normal();
    t_wave();
    t_force();
    t_block();
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    finish_test();
  end
endmodule : t16_timer_tb
